// ==== verilog/tpd_pkg.sv ====
// Function
// - Counter runs only while counter_run is set; stopped otherwise.
// - rotation_direction selects forward at 0, reverse at 1, in both modes.
// - vector_engine_on enables the vector compute engine.
// - With duty_preload_on, new duty applies at next underflow; else at once.
// - compare_source_sel picks software duty at 0, engine compares at 1.
// - drive_mode_sel picks square wave or vector; shifter_output_on gates driver.
// - Counter counts 0 up to reload, then down to 0, centre aligned.
// - Reload, match and duty hold 12 bits; upper nibble reads zero.
// - Phase reference is high while counter is below the compare value.
// - Software duty references the high side; deadtime delays turn-on of both sides.
// - Deadtime lasts setting plus one clocks; zero disables insertion.
// - Six enable bits; both sides enabled gives complementary with deadtime.
// - Six polarity bits; 0 active high, 1 active low.
// - In square wave mode the commutation timer loads enables and polarities.
// - Master output on follows comparators; off drives programmed idle levels.
// - Bus over-current clears master output on; software may set or clear.
// - Six idle level bits give each output level while master is off.
// - Match mode 00 none, 01 up count, 10 down count, 11 both.
// - Match interval 0 flags every cycle, 1 every second cycle.
// - Match flag set by hardware on counter equal match; software clears.
// - Electrical cycle flag set once per cycle; bit 3 is its enable bit.
// - Tick flag set by hardware, cleared by software, whatever enable bit 6 holds.
// - Shifter passes inputs, but forces a phase low when both inputs high.
// - Turn-on of the side that follows an edge is delayed by deadtime.
// - Writing 0 to a flag clears it; writing 1 leaves it.
package tpd_pkg;

    localparam logic [15:0] ADDR_GATE     = 16'h00f8;
    localparam logic [15:0] ADDR_DUTY_H   = 16'h4058;
    localparam logic [15:0] ADDR_DUTY_L   = 16'h4059;
    localparam logic [15:0] ADDR_MATCH_H  = 16'h405a;
    localparam logic [15:0] ADDR_MATCH_L  = 16'h405b;
    localparam logic [15:0] ADDR_SEL_H    = 16'h405c;
    localparam logic [15:0] ADDR_SEL_L    = 16'h405d;
    localparam logic [15:0] ADDR_RELOAD_H = 16'h405e;
    localparam logic [15:0] ADDR_RELOAD_L = 16'h405f;
    localparam logic [15:0] ADDR_DEAD     = 16'h4060;
    localparam logic [15:0] ADDR_STAT     = 16'h4061;
    localparam logic [15:0] ADDR_CTRL     = 16'h4062;

    // Control register bits.
    localparam int CTRL_RUN   = 7;
    localparam int CTRL_DIR   = 6;
    localparam int CTRL_VEC   = 5;
    localparam int CTRL_PRE   = 4;
    localparam int CTRL_SRC   = 3;
    localparam int CTRL_MODE  = 2;
    localparam int CTRL_SHIFT = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hfd;

    // Status register bits.
    localparam int ST_TICK_F  = 7;
    localparam int ST_TICK_E  = 6;
    localparam int ST_ELEC_F  = 5;
    localparam int ST_MATCH_F = 4;
    localparam int ST_ELEC_E  = 3;
    localparam int ST_IVAL    = 2;
    localparam int ST_MODE_HI = 1;
    localparam int ST_MODE_LO = 0;

    // Gate register bits.
    localparam int GATE_MOE = 7;
    localparam logic [7:0] GATE_WMASK = 8'hbf;

    // Phase select layout: enable low at 2p, high at 2p+1, polarity +6.
    localparam int SEL_POL_BASE = 6;

    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [11:0] RST_WORD = 12'h000;
    localparam logic [11:0] CNT_ZERO = 12'h000;
    localparam logic [11:0] CNT_ONE  = 12'h001;

    typedef struct packed {
        logic [11:0] w;
        logic [11:0] v;
        logic [11:0] u;
    } tpd_vcmp_t;

    typedef struct packed {
        logic [11:0]      cnt;
        logic             up;
        logic [7:0]       ctrl;
        logic [7:0]       stat;
        logic [7:0]       gate;
        logic [11:0]      sel;
        logic [11:0]      reload;
        logic [11:0]      match;
        logic [11:0]      duty_act;
        logic [11:0]      duty_pend;
        logic [3:0]       duty_hi;
        logic [7:0]       dead;
        logic             pair;
        logic [2:0]       refs;
        logic [2:0][8:0]  dtc;
        logic [5:0]       bridge;
        logic [7:0]       rdata;
    } tpd_state_t;

endpackage : tpd_pkg

// ==== verilog/tpd_driver.sv ====
`timescale 1ns/1ps
module tpd_driver
    import tpd_pkg::*;
(
    // Clock and reset.
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    // Register port.
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    // Vector engine and commutation timer.
    input  wire tpd_vcmp_t   VEC_CMP,
    input  wire logic        COMMUTE_LOAD,
    input  wire logic [11:0] COMMUTE_SEL,
    // Event inputs.
    input  wire logic        BUS_OVERCURRENT,
    input  wire logic        ELEC_CYCLE_PULSE,
    input  wire logic        TICK_PULSE,
    // Bridge and mode outputs.
    output logic      [5:0]  BRIDGE_OUT,
    output logic             SHIFTER_ON,
    output logic             ROTATION_DIR,
    output logic             VECTOR_ENGINE_ON,
    output logic             DRIVE_MODE,
    output logic      [11:0] CARRIER_COUNT
);

    tpd_state_t s;
    tpd_state_t s_n;

    logic [11:0] cmp;
    logic        ref_now;
    logic        hi_r;
    logic        lo_r;
    logic        hi_o;
    logic        lo_o;
    logic        both;
    logic        underflow;
    logic        m_hit;
    logic        m_set;
    logic [5:0]  post;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        return a == r;
    endfunction : hit

    always_comb begin
        s_n       = s;
        cmp       = CNT_ZERO;
        ref_now   = 1'b0;
        hi_r      = 1'b0;
        lo_r      = 1'b0;
        hi_o      = 1'b0;
        lo_o      = 1'b0;
        both      = 1'b0;
        post      = 6'h00;
        m_hit     = 1'b0;
        m_set     = 1'b0;
        underflow = s.ctrl[CTRL_RUN] && !s.up && (s.cnt == CNT_ZERO);

        // twelve bit fields: upper nibble of each word is dropped.
        if (REG_WR) begin
            if (hit(REG_ADDR, ADDR_CTRL)) begin
                s_n.ctrl = REG_WDATA & CTRL_WMASK;
            end
            if (hit(REG_ADDR, ADDR_DEAD)) begin
                s_n.dead = REG_WDATA;
            end
            if (hit(REG_ADDR, ADDR_GATE)) begin
                s_n.gate = REG_WDATA & GATE_WMASK;
            end
            if (hit(REG_ADDR, ADDR_RELOAD_H)) begin
                s_n.reload[11:8] = REG_WDATA[3:0];
            end
            if (hit(REG_ADDR, ADDR_RELOAD_L)) begin
                s_n.reload[7:0] = REG_WDATA;
            end
            if (hit(REG_ADDR, ADDR_MATCH_H)) begin
                s_n.match[11:8] = REG_WDATA[3:0];
            end
            if (hit(REG_ADDR, ADDR_MATCH_L)) begin
                s_n.match[7:0] = REG_WDATA;
            end
            // square mode ownership: software owns selects in vector.
            if (s.ctrl[CTRL_MODE] && hit(REG_ADDR, ADDR_SEL_H)) begin
                s_n.sel[11:8] = REG_WDATA[3:0];
            end
            if (s.ctrl[CTRL_MODE] && hit(REG_ADDR, ADDR_SEL_L)) begin
                s_n.sel[7:0] = REG_WDATA;
            end
            // staged duty: high byte waits for the low byte.
            if (hit(REG_ADDR, ADDR_DUTY_H)) begin
                s_n.duty_hi = REG_WDATA[3:0];
            end
            if (hit(REG_ADDR, ADDR_DUTY_L)) begin
                s_n.duty_pend = {s.duty_hi, REG_WDATA};
            end
            // write zero clears flags, enables are plain.
            if (hit(REG_ADDR, ADDR_STAT)) begin
                s_n.stat[ST_TICK_E]  = REG_WDATA[ST_TICK_E];
                s_n.stat[ST_ELEC_E]  = REG_WDATA[ST_ELEC_E];
                s_n.stat[ST_IVAL]    = REG_WDATA[ST_IVAL];
                s_n.stat[ST_MODE_HI] = REG_WDATA[ST_MODE_HI];
                s_n.stat[ST_MODE_LO] = REG_WDATA[ST_MODE_LO];
                s_n.stat[ST_TICK_F]  = s.stat[ST_TICK_F] & REG_WDATA[ST_TICK_F];
                s_n.stat[ST_ELEC_F]  = s.stat[ST_ELEC_F] & REG_WDATA[ST_ELEC_F];
                s_n.stat[ST_MATCH_F] = s.stat[ST_MATCH_F]
                                       & REG_WDATA[ST_MATCH_F];
            end
        end

        // duty preload: pending value moves at underflow when preload is on, else at once.
        if (!s.ctrl[CTRL_PRE]) begin
            s_n.duty_act = s_n.duty_pend;
        end else if (underflow) begin
            s_n.duty_act = s.duty_pend;
        end

        // commutation load in square wave mode.
        if (!s.ctrl[CTRL_MODE] && COMMUTE_LOAD) begin
            s_n.sel = COMMUTE_SEL;
        end

        // over-current wins over a software set.
        if (BUS_OVERCURRENT) begin
            s_n.gate[GATE_MOE] = 1'b0;
        end

        // run gate, hold at zero, up then down.
        if (!s.ctrl[CTRL_RUN] || (s.reload == CNT_ZERO)) begin
            s_n.cnt = CNT_ZERO;
            s_n.up  = 1'b1;
        end else if (s.up) begin
            if (s.cnt >= s.reload) begin
                s_n.up  = 1'b0;
                s_n.cnt = s.cnt - CNT_ONE;
            end else begin
                s_n.cnt = s.cnt + CNT_ONE;
            end
        end else begin
            if (s.cnt == CNT_ZERO) begin
                s_n.up  = 1'b1;
                s_n.cnt = CNT_ONE;
            end else begin
                s_n.cnt = s.cnt - CNT_ONE;
            end
        end

        // match mode decode on the current count direction.
        m_hit = s.ctrl[CTRL_RUN] && (s.cnt == s.match)
                && ((s.stat[ST_MODE_LO] && s.up)
                    || (s.stat[ST_MODE_HI] && !s.up));
        // every cycle or every second cycle.
        if (m_hit) begin
            m_set = !s.stat[ST_IVAL] || s.pair;
            if (s.stat[ST_IVAL]) begin
                s_n.pair = !s.pair;
            end
        end
        // match flag set wins over clear.
        if (m_set) begin
            s_n.stat[ST_MATCH_F] = 1'b1;
        end
        if (ELEC_CYCLE_PULSE) begin
            s_n.stat[ST_ELEC_F] = 1'b1;
        end
        if (TICK_PULSE) begin
            s_n.stat[ST_TICK_F] = 1'b1;
        end

        for (int p = 0; p < 3; p++) begin
            cmp = s.ctrl[CTRL_SRC] ? VEC_CMP[p*12 +: 12] : s.duty_act;
            // reference high below the compare value.
            ref_now       = s.cnt < cmp;
            s_n.refs[p]   = ref_now;
            // deadtime counter loads setting plus one on an edge.
            if ((ref_now != s.refs[p]) && (s.dead != RST_BYTE)) begin
                s_n.dtc[p] = {1'b0, s.dead} + 9'h001;
            end else if (s.dtc[p] != 9'h000) begin
                s_n.dtc[p] = s.dtc[p] - 9'h001;
            end
            // software duty references high side; engine low side.
            hi_r = s.ctrl[CTRL_SRC] ? !s.refs[p] : s.refs[p];
            lo_r = !hi_r;
            // complementary pair only when both sides enabled.
            both = s.sel[2*p] && s.sel[2*p+1];
            if (both) begin
                // the side turning on waits out the deadtime.
                hi_o = hi_r && (s.dtc[p] == 9'h000);
                lo_o = lo_r && (s.dtc[p] == 9'h000);
            end else begin
                hi_o = s.sel[2*p+1] && hi_r;
                lo_o = s.sel[2*p] && lo_r;
            end
            hi_o = hi_o ^ s.sel[SEL_POL_BASE+2*p+1];
            lo_o = lo_o ^ s.sel[SEL_POL_BASE+2*p];
            // master output on, idle levels otherwise.
            if (!s.gate[GATE_MOE]) begin
                hi_o = s.gate[2*p];
                lo_o = s.gate[2*p+1];
            end
            post[2*p]   = hi_o;
            post[2*p+1] = lo_o;
            if (!s.ctrl[CTRL_SHIFT] || (hi_o && lo_o)) begin
                post[2*p]   = 1'b0;
                post[2*p+1] = 1'b0;
            end
        end
        s_n.bridge = post;

        // upper nibble of word registers reads as zero.
        s_n.rdata = RST_BYTE;
        if (REG_RD) begin
            case (REG_ADDR)
                ADDR_CTRL:     s_n.rdata = s.ctrl;
                ADDR_STAT:     s_n.rdata = s.stat;
                ADDR_DEAD:     s_n.rdata = s.dead;
                ADDR_GATE:     s_n.rdata = s.gate;
                ADDR_RELOAD_H: s_n.rdata = {4'h0, s.reload[11:8]};
                ADDR_RELOAD_L: s_n.rdata = s.reload[7:0];
                ADDR_MATCH_H:  s_n.rdata = {4'h0, s.match[11:8]};
                ADDR_MATCH_L:  s_n.rdata = s.match[7:0];
                ADDR_SEL_H:    s_n.rdata = {4'h0, s.sel[11:8]};
                ADDR_SEL_L:    s_n.rdata = s.sel[7:0];
                ADDR_DUTY_H:   s_n.rdata = {4'h0, s.duty_pend[11:8]};
                ADDR_DUTY_L:   s_n.rdata = s.duty_pend[7:0];
                default:       s_n.rdata = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            s <= '0;
        end else begin
            s <= s_n;
        end
    end

    assign REG_RDATA        = s.rdata;
    assign BRIDGE_OUT       = s.bridge;
    assign SHIFTER_ON       = s.ctrl[CTRL_SHIFT];
    assign DRIVE_MODE       = s.ctrl[CTRL_MODE];
    assign ROTATION_DIR     = s.ctrl[CTRL_DIR];
    assign VECTOR_ENGINE_ON = s.ctrl[CTRL_VEC];
    assign CARRIER_COUNT    = s.cnt;

    // Checks.
    sequence dt_edge_s;
        (s.refs[0] != $past(s.refs[0])) && ($past(s.dead) != 8'h00);
    endsequence

    sequence dt_load_s;
        s.dtc[0] == ({1'b0, $past(s.dead)} + 9'h001);
    endsequence

    sequence pre_hold_s;
        s.ctrl[CTRL_PRE] && !underflow && !s.ctrl[CTRL_SRC];
    endsequence

    stopped_count_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        !s.ctrl[CTRL_RUN] |=> (s.cnt == 12'h000) && s.up)
        else $error("counter moved while stopped");

    carrier_peak_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        s.ctrl[CTRL_RUN] && s.up && (s.reload > 12'h001)
        && (s.cnt == s.reload) && $stable(s.reload) && !REG_WR
        |=> !s.up && (s.cnt == $past(s.reload) - 12'h001))
        else $error("carrier did not turn at reload");

    dead_load_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        dt_edge_s |-> dt_load_s)
        else $error("deadtime count not loaded");

    idle_level_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        !s.gate[GATE_MOE] && s.ctrl[CTRL_SHIFT]
        && !(s.gate[0] && s.gate[1])
        |=> BRIDGE_OUT[1:0] == $past(s.gate[1:0]))
        else $error("idle level not driven");

    shift_lock_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        !(BRIDGE_OUT[0] && BRIDGE_OUT[1]) && !(BRIDGE_OUT[2] && BRIDGE_OUT[3])
        && !(BRIDGE_OUT[4] && BRIDGE_OUT[5]))
        else $error("both sides of a phase high");

    ocp_clear_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        BUS_OVERCURRENT |=> !s.gate[GATE_MOE] ##1 BRIDGE_OUT == 6'h00
        || s.gate[GATE_MOE] || !s.ctrl[CTRL_SHIFT] || (s.gate[5:0] != 6'h00))
        else $error("over-current did not clear output");

    flag_clear_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        REG_WR && (REG_ADDR == ADDR_STAT) && !REG_WDATA[ST_MATCH_F] && !m_set
        |=> !s.stat[ST_MATCH_F])
        else $error("match flag not cleared by zero write");

    match_set_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        m_set |=> s.stat[ST_MATCH_F])
        else $error("match flag not set");

    preload_hold_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        pre_hold_s ##1 s.ctrl[CTRL_PRE] |-> $stable(s.duty_act))
        else $error("preloaded duty changed before underflow");

    word_top_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        REG_RD && (REG_ADDR == ADDR_RELOAD_H) |=> REG_RDATA[7:4] == 4'h0)
        else $error("upper nibble not zero");

    rdata_idle_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        !REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data not zero outside a read");

    elec_flag_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        ELEC_CYCLE_PULSE |=> s.stat[ST_ELEC_F])
        else $error("electrical cycle flag not set");

    tick_flag_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        TICK_PULSE |=> s.stat[ST_TICK_F])
        else $error("tick flag not set");

    duty_direct_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        !s.ctrl[CTRL_PRE] && !REG_WR |=> s.duty_act == $past(s.duty_pend))
        else $error("direct duty not applied");

    preload_take_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        s.ctrl[CTRL_PRE] && underflow |=> s.duty_act == $past(s.duty_pend))
        else $error("preloaded duty not taken at underflow");

    match_off_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (s.stat[ST_MODE_HI:ST_MODE_LO] == 2'b00) |-> !m_set)
        else $error("match flagged with mode off");

    count_down_a: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        s.ctrl[CTRL_RUN] && !s.up && (s.cnt != 12'h000)
        && (s.reload != 12'h000)
        |=> s.cnt == $past(s.cnt) - 12'h001)
        else $error("carrier did not count down");

endmodule : tpd_driver

// ==== tb/tpd_shifter_model.sv ====
`timescale 1ns/1ps
module tpd_shifter_model
    import tpd_pkg::*;
(
    // Bridge side.
    input  wire logic [5:0] bridge_in,
    input  wire logic       enable,
    // Switch side.
    output logic      [2:0] hi_out,
    output logic      [2:0] lo_out
);
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            hi_out[p] = enable & bridge_in[2*p] & ~bridge_in[2*p+1];
            lo_out[p] = enable & bridge_in[2*p+1] & ~bridge_in[2*p];
        end
    end
endmodule : tpd_shifter_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import tpd_pkg::*;
;
    logic        clk;
    logic        rst;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr_s;
    logic        rd_s;
    logic [7:0]  rdata;
    tpd_vcmp_t   vec;
    logic        com_ld;
    logic [11:0] com_sel;
    logic        ocur;
    logic        elec;
    logic        tick;
    logic [5:0]  bridge;
    logic        shift_on;
    logic        dir;
    logic        veng;
    logic        dmode;
    logic [11:0] cnt;
    logic [2:0]  hi_sw;
    logic [2:0]  lo_sw;
    int          miscompares;
    int          n_tests;

    tpd_driver tpd_driver_i (
        .SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .VEC_CMP(vec),
        .COMMUTE_LOAD(com_ld), .COMMUTE_SEL(com_sel),
        .BUS_OVERCURRENT(ocur), .ELEC_CYCLE_PULSE(elec), .TICK_PULSE(tick),
        .BRIDGE_OUT(bridge), .SHIFTER_ON(shift_on), .ROTATION_DIR(dir),
        .VECTOR_ENGINE_ON(veng), .DRIVE_MODE(dmode), .CARRIER_COUNT(cnt));

    tpd_shifter_model tpd_shifter_model_i (
        .bridge_in(bridge), .enable(shift_on), .hi_out(hi_sw),
        .lo_out(lo_sw));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic chk12(input string n, input logic [11:0] e,
                         input logic [11:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk12

    task automatic chkn(input string n, input int e, input int g);
        n_tests++;
        if (g != e) begin
            miscompares++;
            $display("FAIL %s expected %0d seen %0d", n, e, g);
        end
    endtask : chkn

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask : wr

    task automatic chkrd(input string n, input logic [15:0] a,
                         input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk8(n, e, rdata);
    endtask : chkrd

    task automatic run_for(input int n);
        wr(ADDR_CTRL, 8'h80);
        repeat (n) @(posedge clk);
        wr(ADDR_CTRL, 8'h00);
    endtask : run_for

    // Counts switch-on cycles of phase U over two whole carrier periods.
    task automatic pwm_row(input logic [7:0] sel, input logic [7:0] dead,
                           input logic [7:0] ctrl, input int euh,
                           input int eul);
        int uh;
        int ul;
        int both;
        uh = 0;
        ul = 0;
        both = 0;
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_SEL_L, sel);
        wr(ADDR_DEAD, dead);
        wr(ADDR_CTRL, ctrl);
        repeat (15) @(posedge clk);
        repeat (20) begin
            @(posedge clk);
            #1;
            if (hi_sw[0] === 1'b1) uh++;
            if (lo_sw[0] === 1'b1) ul++;
            if ((bridge[0] & bridge[1]) !== 1'b0) both++;
        end
        chkn("u high on cycles", euh, uh);
        chkn("u low on cycles", eul, ul);
        chkn("u overlap cycles", 0, both);
    endtask : pwm_row

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end

    initial begin
        logic [15:0] addrs [12];
        int          ec;
        logic        eu;
        addrs = '{ADDR_GATE, ADDR_DUTY_H, ADDR_DUTY_L, ADDR_MATCH_H,
                  ADDR_MATCH_L, ADDR_SEL_H, ADDR_SEL_L, ADDR_RELOAD_H,
                  ADDR_RELOAD_L, ADDR_DEAD, ADDR_STAT, ADDR_CTRL};
        rst = 1'b1;
        addr = 16'h0000;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        vec = '{w: 12'h000, v: 12'h000, u: 12'h004};
        com_ld = 1'b0;
        com_sel = 12'h000;
        ocur = 1'b0;
        elec = 1'b0;
        tick = 1'b0;
        miscompares = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) chkrd("reset value", addrs[i], 8'h00);
        wr(16'h4063, 8'hff);
        chkrd("unmapped", 16'h4063, 8'h00);
        $display("test registers done");
        wr(ADDR_CTRL, 8'h67);
        chkrd("control", ADDR_CTRL, 8'h65);
        chk8("mode pins", 8'h0f, {4'h0, dir, veng, dmode, shift_on});
        wr(ADDR_RELOAD_H, 8'hff);
        chkrd("reload high", ADDR_RELOAD_H, 8'h0f);
        wr(ADDR_RELOAD_H, 8'h00);
        wr(ADDR_RELOAD_L, 8'h05);
        chk12("stopped count", 12'h000, cnt);
        wr(ADDR_CTRL, 8'h80);
        for (int i = 0; i < 20 && cnt !== 12'h001; i++) begin
            @(posedge clk);
            #1;
        end
        ec = 1;
        eu = 1'b1;
        repeat (12) begin
            if (eu && ec == 5) eu = 1'b0;
            else if (!eu && ec == 0) eu = 1'b1;
            ec = eu ? ec + 1 : ec - 1;
            @(posedge clk);
            #1;
            chk12("carrier count", 12'(ec), cnt);
        end
        wr(ADDR_CTRL, 8'h00);
        repeat (5) @(posedge clk);
        #1;
        chk12("halted count", 12'h000, cnt);
        $display("test counter done");
        wr(ADDR_SEL_L, 8'hff);
        chkrd("select sw write", ADDR_SEL_L, 8'h00);
        @(posedge clk);
        com_sel <= 12'h3a5;
        com_ld  <= 1'b1;
        @(posedge clk);
        com_ld  <= 1'b0;
        chkrd("select low", ADDR_SEL_L, 8'ha5);
        chkrd("select high", ADDR_SEL_H, 8'h03);
        $display("test commutation done");
        wr(ADDR_MATCH_L, 8'h03);
        wr(ADDR_STAT, 8'h05);
        run_for(4);
        chkrd("skipped match", ADDR_STAT, 8'h05);
        run_for(4);
        chkrd("second match", ADDR_STAT, 8'h15);
        wr(ADDR_STAT, 8'h15);
        chkrd("flag write one", ADDR_STAT, 8'h15);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_STAT, 8'(m));
            run_for(12);
            chkrd("match mode", ADDR_STAT,
                  (m == 0) ? 8'h00 : (8'(m) | 8'h10));
        end
        $display("test match done");
        wr(ADDR_STAT, 8'h00);
        @(posedge clk);
        elec <= 1'b1;
        tick <= 1'b1;
        @(posedge clk);
        elec <= 1'b0;
        tick <= 1'b0;
        chkrd("event flags", ADDR_STAT, 8'ha0);
        wr(ADDR_STAT, 8'h48);
        chkrd("flags cleared", ADDR_STAT, 8'h48);
        $display("test events done");
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_GATE, 8'hff);
        chkrd("gate reserved", ADDR_GATE, 8'hbf);
        wr(ADDR_GATE, 8'h95);
        @(posedge clk);
        ocur <= 1'b1;
        @(posedge clk);
        ocur <= 1'b0;
        chkrd("gate after fault", ADDR_GATE, 8'h15);
        repeat (3) @(posedge clk);
        #1;
        chk8("idle levels", 8'h15, {2'b00, bridge});
        wr(ADDR_GATE, 8'h80);
        wr(ADDR_DUTY_H, 8'h00);
        wr(ADDR_DUTY_L, 8'h04);
        wr(ADDR_DUTY_H, 8'h0f);
        chkrd("duty half write", ADDR_DUTY_H, 8'h00);
        chkrd("duty low", ADDR_DUTY_L, 8'h04);
        $display("test outputs done");
        pwm_row(8'h03, 8'h00, 8'h85, 14, 6);
        pwm_row(8'h03, 8'h01, 8'h85, 10, 2);
        pwm_row(8'hc3, 8'h00, 8'h85, 6, 14);
        pwm_row(8'h03, 8'h00, 8'h8d, 6, 14);
        pwm_row(8'h02, 8'h00, 8'h85, 14, 0);
        // A preloaded zero duty must wait for the first underflow.
        wr(ADDR_CTRL, 8'h15);
        wr(ADDR_DUTY_H, 8'h00);
        wr(ADDR_DUTY_L, 8'h00);
        repeat (4) @(posedge clk);
        #1;
        chk8("preload held", 8'h01, {7'h00, hi_sw[0]});
        wr(ADDR_CTRL, 8'h95);
        repeat (20) @(posedge clk);
        #1;
        chk8("preload taken", 8'h00, {7'h00, hi_sw[0]});
        $display("test pwm done");
        summarize();
    end
endmodule : tb_top
